// ==== logic/ccat_regs.sv ====
// clock source select and agc timing register bank with derived time constants
`timescale 1ns/1ps
`default_nettype none
module ccat_regs (
    input wire logic clock,
    input wire logic rst_b,
    input var ccat_pkg::ccat_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic mclk_pin,
    input wire logic general_pin_two,
    input wire logic bclk_pin,
    input wire logic pll_divided_output,
    input wire logic divider_path_output,
    output logic codec_core_clock_in,
    output logic divider_path_input,
    output logic pll_reference_input,
    input wire logic [3:0] codec_rate_ratio,
    input wire logic [15:0] legacy_left_attack_ms,
    input wire logic [15:0] legacy_left_decay_ms,
    input wire logic [15:0] legacy_right_attack_ms,
    output logic [15:0] left_attack_ms,
    output logic [15:0] left_decay_ms,
    output logic [15:0] right_attack_ms
);

    // stored register state
    logic core_sel_reg;
    logic core_sel_next;
    logic [7:0] gen_reg;
    logic [7:0] gen_next;
    ccat_pkg::ccat_agc_t latk_reg;
    ccat_pkg::ccat_agc_t latk_next;
    ccat_pkg::ccat_agc_t ldec_reg;
    ccat_pkg::ccat_agc_t ldec_next;
    ccat_pkg::ccat_agc_t ratk_reg;
    ccat_pkg::ccat_agc_t ratk_next;

    // read port state
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    // derived time constants
    logic [15:0] latk_calc;
    logic [15:0] ldec_calc;
    logic [15:0] ratk_calc;
    logic [15:0] latk_ms_reg;
    logic [15:0] latk_ms_next;
    logic [15:0] ldec_ms_reg;
    logic [15:0] ldec_ms_next;
    logic [15:0] ratk_ms_reg;
    logic [15:0] ratk_ms_next;

    logic [1:0] div_src;
    logic [1:0] pll_src;

    // route one of the three clock pins; the reserved code parks the output low
    function automatic logic pick_src(
        input logic [1:0] code,
        input logic m,
        input logic g,
        input logic b
    );
        logic r;
        r = 1'b0;
        case (code)
            ccat_pkg::CCAT_SRC_MCLK: r = m;
            ccat_pkg::CCAT_SRC_GPIN2: r = g;
            ccat_pkg::CCAT_SRC_BCLK: r = b;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_src

    // register write decode; only bit 0 of the clock register stores
    always_comb
    begin
        core_sel_next = core_sel_reg;
        gen_next = gen_reg;
        latk_next = latk_reg;
        ldec_next = ldec_reg;
        ratk_next = ratk_reg;
        if (!rst_b)
        begin
            core_sel_next = ccat_pkg::CCAT_RST_CLK[ccat_pkg::CCAT_CORE_SEL_BIT];
            gen_next = ccat_pkg::CCAT_RST_GEN;
            latk_next = ccat_pkg::CCAT_RST_AGC;
            ldec_next = ccat_pkg::CCAT_RST_AGC;
            ratk_next = ccat_pkg::CCAT_RST_AGC;
        end
        else if (reg_req.wr)
        begin
            case (reg_req.addr)
                ccat_pkg::CCAT_ADDR_CLK: core_sel_next = reg_req.data[ccat_pkg::CCAT_CORE_SEL_BIT];
                ccat_pkg::CCAT_ADDR_GEN: gen_next = reg_req.data;
                ccat_pkg::CCAT_ADDR_LATK: latk_next = reg_req.data;
                ccat_pkg::CCAT_ADDR_LDEC: ldec_next = reg_req.data;
                ccat_pkg::CCAT_ADDR_RATK: ratk_next = reg_req.data;
                default: core_sel_next = core_sel_reg;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        core_sel_reg <= core_sel_next;
        gen_reg <= gen_next;
        latk_reg <= latk_next;
        ldec_reg <= ldec_next;
        ratk_reg <= ratk_next;
    end

    // read path: data lands one cycle after the request with a valid pulse
    always_comb
    begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (!rst_b)
        begin
            rdata_next = ccat_pkg::CCAT_RD_UNMAPPED;
        end
        else if (reg_req.rd)
        begin
            rvalid_next = 1'b1;
            case (reg_req.addr)
                ccat_pkg::CCAT_ADDR_CLK: rdata_next = {7'h00, core_sel_reg};
                ccat_pkg::CCAT_ADDR_GEN: rdata_next = gen_reg;
                ccat_pkg::CCAT_ADDR_LATK: rdata_next = latk_reg;
                ccat_pkg::CCAT_ADDR_LDEC: rdata_next = ldec_reg;
                ccat_pkg::CCAT_ADDR_RATK: rdata_next = ratk_reg;
                default: rdata_next = ccat_pkg::CCAT_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        rdata_reg <= rdata_next;
        rvalid_reg <= rvalid_next;
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // clock routing is combinational so no edge is lost or delayed
    always_comb
    begin
        div_src = gen_reg[ccat_pkg::CCAT_DIV_SRC_LSB +: 2];
        pll_src = gen_reg[ccat_pkg::CCAT_PLL_SRC_LSB +: 2];
        divider_path_input = pick_src(div_src, mclk_pin, general_pin_two, bclk_pin);
        pll_reference_input = pick_src(pll_src, mclk_pin, general_pin_two, bclk_pin);
        codec_core_clock_in = core_sel_reg ? divider_path_output : pll_divided_output;
    end

    // one calculator per timing register; right decay lives elsewhere
    ccat_time_calc #(
        .IS_DECAY(1'b0)
    ) u_latk (
        .cfg(latk_reg),
        .legacy_ms(legacy_left_attack_ms),
        .rate_ratio(codec_rate_ratio),
        .time_ms(latk_calc)
    );

    ccat_time_calc #(
        .IS_DECAY(1'b1)
    ) u_ldec (
        .cfg(ldec_reg),
        .legacy_ms(legacy_left_decay_ms),
        .rate_ratio(codec_rate_ratio),
        .time_ms(ldec_calc)
    );

    ccat_time_calc #(
        .IS_DECAY(1'b0)
    ) u_ratk (
        .cfg(ratk_reg),
        .legacy_ms(legacy_right_attack_ms),
        .rate_ratio(codec_rate_ratio),
        .time_ms(ratk_calc)
    );

    // time constants are registered so the gain engine sees clean values
    always_comb
    begin
        latk_ms_next = latk_calc;
        ldec_ms_next = ldec_calc;
        ratk_ms_next = ratk_calc;
        if (!rst_b)
        begin
            latk_ms_next = 16'h0000;
            ldec_ms_next = 16'h0000;
            ratk_ms_next = 16'h0000;
        end
    end

    always_ff @(posedge clock)
    begin
        latk_ms_reg <= latk_ms_next;
        ldec_ms_reg <= ldec_ms_next;
        ratk_ms_reg <= ratk_ms_next;
    end

    assign left_attack_ms = latk_ms_reg;
    assign left_decay_ms = ldec_ms_reg;
    assign right_attack_ms = ratk_ms_reg;

    // a write to bit 0 steers the core clock from the next cycle
    AST_CORE_SEL_WRITE: assert property (@(posedge clock) disable iff (!rst_b)
        reg_req.wr && reg_req.addr == ccat_pkg::CCAT_ADDR_CLK
        |=> codec_core_clock_in == ($past(reg_req.data[0]) ? divider_path_output : pll_divided_output))
        else $error("core clock does not follow written select");

    // upper clock register bits always read back zero
    AST_CLK_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
        reg_req.rd && reg_req.addr == ccat_pkg::CCAT_ADDR_CLK |=> reg_rvalid && reg_rdata[7:1] == 7'h00)
        else $error("clock register upper bits not zero");

    // divider input follows bit clock pin for code 10
    AST_DIV_SRC: assert property (@(posedge clock) disable iff (!rst_b)
        gen_reg[7:6] == 2'h2 |-> divider_path_input == bclk_pin)
        else $error("divider input source wrong");

    // pll reference follows general pin two for code 01
    AST_PLL_SRC: assert property (@(posedge clock) disable iff (!rst_b)
        gen_reg[5:4] == 2'h1 |-> pll_reference_input == general_pin_two)
        else $error("pll reference source wrong");

    // after reset the generation register reads 0x02
    AST_GEN_RESET: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(rst_b) |-> gen_reg == 8'h02 && latk_reg == 8'h00)
        else $error("generation register reset value wrong");

    // legacy source passes through untouched while select is clear
    AST_LATK_LEGACY: assert property (@(posedge clock) disable iff (!rst_b)
        !latk_reg.sel ##1 !latk_reg.sel |-> left_attack_ms == $past(legacy_left_attack_ms))
        else $error("left attack not taken from legacy source");

    // longest left attack is 11 ms x 128
    AST_LATK_MAX: assert property (@(posedge clock) disable iff (!rst_b)
        latk_reg == 8'hFC |=> left_attack_ms == 16'h0580)
        else $error("left attack scaling wrong");

    // 50 ms x 2 is well under any cap
    AST_LDEC_MULT: assert property (@(posedge clock) disable iff (!rst_b)
        ldec_reg == 8'h84 |=> left_decay_ms == 16'h0064)
        else $error("left decay scaling wrong");

    // 350 ms x 128 is cut to 4 s at ratio 1
    AST_LDEC_CAP: assert property (@(posedge clock) disable iff (!rst_b)
        ldec_reg == 8'hFC && codec_rate_ratio == 4'h2 |=> left_decay_ms == 16'h0FA0)
        else $error("left decay cap wrong");

    // right attack: 10 ms baseline, legacy when select clear
    AST_RATK: assert property (@(posedge clock) disable iff (!rst_b)
        ratk_reg == 8'hC0 |=> right_attack_ms == 16'h000A)
        else $error("right attack time wrong");

    // divider input sits on the master clock pin for code 00, the reset choice
    AST_DIV_MCLK: assert property (@(posedge clock) disable iff (!rst_b)
        gen_reg[7:6] == ccat_pkg::CCAT_SRC_MCLK |-> divider_path_input == mclk_pin)
        else $error("divider input not on master clock pin");

    // reserved divider code parks the routed clock low rather than guessing a pin
    AST_DIV_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
        gen_reg[7:6] == ccat_pkg::CCAT_SRC_RSVD |-> !divider_path_input)
        else $error("reserved divider code does not park low");

    // reserved pll reference code parks the routed clock low
    AST_PLL_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
        gen_reg[5:4] == ccat_pkg::CCAT_SRC_RSVD |-> !pll_reference_input)
        else $error("reserved pll code does not park low");

    // right attack passes the legacy time through while select is clear
    AST_RATK_LEGACY: assert property (@(posedge clock) disable iff (!rst_b)
        !ratk_reg.sel ##1 !ratk_reg.sel |-> right_attack_ms == $past(legacy_right_attack_ms))
        else $error("right attack not taken from legacy source");

    // legacy decay passes uncapped while select is clear
    AST_LDEC_LEGACY: assert property (@(posedge clock) disable iff (!rst_b)
        !ldec_reg.sel ##1 !ldec_reg.sel |-> left_decay_ms == $past(legacy_left_decay_ms))
        else $error("left decay not taken from legacy source");

    // core clock select only moves on a write to its own address
    AST_CORE_SEL_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
        !(reg_req.wr && reg_req.addr == ccat_pkg::CCAT_ADDR_CLK) |=> $stable(core_sel_reg))
        else $error("core clock select changed without a write");

endmodule : ccat_regs
`default_nettype wire

// ==== inc/ccat_pkg.sv ====
// constants and carrier types for the clock source and agc timing register bank
package ccat_pkg;

    // register port geometry
    localparam int CCAT_AW = 7;
    localparam int CCAT_DW = 8;
    localparam int CCAT_MS_W = 16;

    // register addresses on the control bus
    localparam logic [6:0] CCAT_ADDR_CLK = 7'h65;
    localparam logic [6:0] CCAT_ADDR_GEN = 7'h66;
    localparam logic [6:0] CCAT_ADDR_LATK = 7'h67;
    localparam logic [6:0] CCAT_ADDR_LDEC = 7'h68;
    localparam logic [6:0] CCAT_ADDR_RATK = 7'h69;

    // reset values
    localparam logic [7:0] CCAT_RST_CLK = 8'h00;
    localparam logic [7:0] CCAT_RST_GEN = 8'h02;
    localparam logic [7:0] CCAT_RST_AGC = 8'h00;
    localparam logic [7:0] CCAT_RD_UNMAPPED = 8'h00;

    // field positions
    localparam int CCAT_CORE_SEL_BIT = 0;
    localparam int CCAT_DIV_SRC_LSB = 6;
    localparam int CCAT_PLL_SRC_LSB = 4;
    localparam int CCAT_GEN_LOW_LSB = 0;
    localparam int CCAT_GEN_LOW_W = 4;

    // source codes for the divider and pll input selectors
    localparam logic [1:0] CCAT_SRC_MCLK = 2'h0;
    localparam logic [1:0] CCAT_SRC_GPIN2 = 2'h1;
    localparam logic [1:0] CCAT_SRC_BCLK = 2'h2;
    localparam logic [1:0] CCAT_SRC_RSVD = 2'h3;

    // baseline times in ms, indexed by the two-bit baseline code
    localparam logic [15:0] CCAT_ATK_BASE_MS [4] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B};
    localparam logic [15:0] CCAT_DEC_BASE_MS [4] = '{16'h0032, 16'h0096, 16'h00FA, 16'h015E};

    // codec rate ratio, coded as twice the ratio
    localparam logic [3:0] CCAT_NR_1P0 = 4'h2;
    localparam logic [3:0] CCAT_NR_1P5 = 4'h3;
    localparam logic [3:0] CCAT_NR_2P0 = 4'h4;
    localparam logic [3:0] CCAT_NR_2P5 = 4'h5;
    localparam logic [3:0] CCAT_NR_3P0 = 4'h6;
    localparam logic [3:0] CCAT_NR_3P5 = 4'h7;
    localparam logic [3:0] CCAT_NR_4P0 = 4'h8;
    localparam logic [3:0] CCAT_NR_4P5 = 4'h9;
    localparam logic [3:0] CCAT_NR_5P0 = 4'hA;
    localparam logic [3:0] CCAT_NR_5P5 = 4'hB;
    localparam logic [3:0] CCAT_NR_6P0 = 4'hC;

    // longest decay per ratio step, in ms
    localparam logic [15:0] CCAT_CAP_4S0 = 16'h0FA0;
    localparam logic [15:0] CCAT_CAP_5S6 = 16'h15E0;
    localparam logic [15:0] CCAT_CAP_8S0 = 16'h1F40;
    localparam logic [15:0] CCAT_CAP_9S6 = 16'h2580;
    localparam logic [15:0] CCAT_CAP_11S2 = 16'h2BC0;
    localparam logic [15:0] CCAT_CAP_16S0 = 16'h3E80;
    localparam logic [15:0] CCAT_CAP_19S2 = 16'h4B00;
    localparam logic [15:0] CCAT_CAP_22S4 = 16'h5780;

    // one agc timing register, laid out bit for bit
    typedef struct packed {
        logic sel;
        logic [1:0] base;
        logic [2:0] mult;
        logic [1:0] rsvd;
    } ccat_agc_t;

    // one register access from the control bus slave
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] data;
    } ccat_req_t;

endpackage : ccat_pkg

// ==== logic/ccat_time_calc.sv ====
// effective agc time constant from one timing register
`timescale 1ns/1ps
`default_nettype none
module ccat_time_calc #(
    parameter bit IS_DECAY = 1'b0
) (
    input var ccat_pkg::ccat_agc_t cfg,
    input wire logic [15:0] legacy_ms,
    input wire logic [3:0] rate_ratio,
    output logic [15:0] time_ms
);

    logic [15:0] base_ms;
    logic [15:0] scaled_ms;
    logic [15:0] cap_ms;

    // baseline scaled by two to the multiplier code; widest is 350 ms x 128
    always_comb
    begin
        base_ms = IS_DECAY ? ccat_pkg::CCAT_DEC_BASE_MS[cfg.base] : ccat_pkg::CCAT_ATK_BASE_MS[cfg.base];
        scaled_ms = 16'(base_ms << cfg.mult);
    end

    // decay ceiling per rate ratio; unlisted ratios fall back to the widest cap
    always_comb
    begin
        case (rate_ratio)
            ccat_pkg::CCAT_NR_1P0: cap_ms = ccat_pkg::CCAT_CAP_4S0;
            ccat_pkg::CCAT_NR_1P5: cap_ms = ccat_pkg::CCAT_CAP_5S6;
            ccat_pkg::CCAT_NR_2P0: cap_ms = ccat_pkg::CCAT_CAP_8S0;
            ccat_pkg::CCAT_NR_2P5: cap_ms = ccat_pkg::CCAT_CAP_9S6;
            ccat_pkg::CCAT_NR_3P0,
            ccat_pkg::CCAT_NR_3P5: cap_ms = ccat_pkg::CCAT_CAP_11S2;
            ccat_pkg::CCAT_NR_4P0,
            ccat_pkg::CCAT_NR_4P5: cap_ms = ccat_pkg::CCAT_CAP_16S0;
            ccat_pkg::CCAT_NR_5P0: cap_ms = ccat_pkg::CCAT_CAP_19S2;
            default: cap_ms = ccat_pkg::CCAT_CAP_22S4;
        endcase
    end

    // legacy source wins while select is clear; new fields are ignored then
    always_comb
    begin
        if (!cfg.sel)
        begin
            time_ms = legacy_ms;
        end
        else if (IS_DECAY && (scaled_ms > cap_ms))
        begin
            time_ms = cap_ms;
        end
        else
        begin
            time_ms = scaled_ms;
        end
    end

endmodule : ccat_time_calc
`default_nettype wire

// ==== verification/ccat_host_model.sv ====
// host model that issues register accesses into the bank over its request port
`timescale 1ns/1ps
`default_nettype none
module ccat_host_model (
    input wire logic clock,
    output var ccat_pkg::ccat_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // quiet bus from time zero
    initial
    begin
        reg_req = '0;
    end

    // idle address and data show inverted leftovers so nothing rides on stale values
    task automatic release_bus();
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.data = ~reg_req.data;
    endtask : release_bus

    // one-cycle write pulse, reserved bits forced to their only legal values
    task automatic write(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == ccat_pkg::CCAT_ADDR_CLK)
            d[7:1] = 7'h00;
        if (addr == ccat_pkg::CCAT_ADDR_GEN)
            d[3:0] = 4'h2;
        if (addr >= ccat_pkg::CCAT_ADDR_LATK && addr <= ccat_pkg::CCAT_ADDR_RATK)
            d[1:0] = 2'h0;
        @(posedge clock);
        #1;
        reg_req.wr = 1'b1;
        reg_req.addr = addr;
        reg_req.data = d;
        @(posedge clock);
        #1;
        release_bus();
    endtask : write

    // one-cycle read pulse; answer stands in the cycle after the taking edge
    task automatic read(input logic [6:0] addr, output logic [7:0] data, output logic valid);
        @(posedge clock);
        #1;
        reg_req.rd = 1'b1;
        reg_req.addr = addr;
        @(posedge clock);
        #1;
        release_bus();
        valid = reg_rvalid;
        data = reg_rdata;
    endtask : read
endmodule : ccat_host_model
`default_nettype wire

// ==== verification/ccat_regs_bench.sv ====
// self-checking bench for the clock source and agc timing register bank
`timescale 1ns/1ps
`default_nettype none
module ccat_regs_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    ccat_pkg::ccat_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic mclk_pin = 1'b0, general_pin_two = 1'b0, bclk_pin = 1'b0;
    logic pll_divided_output = 1'b0, divider_path_output = 1'b0;
    logic codec_core_clock_in, divider_path_input, pll_reference_input;
    logic [3:0] codec_rate_ratio = 4'h2;
    logic [15:0] legacy_left_attack_ms = 16'h1234;
    logic [15:0] legacy_left_decay_ms = 16'hFFFF;
    logic [15:0] legacy_right_attack_ms = 16'h0ABC;
    logic [15:0] left_attack_ms, left_decay_ms, right_attack_ms;
    int n_fail = 0;
    int checked = 0;
    logic [15:0] atk_tbl [4] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B};
    logic [15:0] dec_tbl [4] = '{16'h0032, 16'h0096, 16'h00FA, 16'h015E};

    // 50 ns period
    always #25 clock = ~clock;

    ccat_regs uut (
        .clock, .rst_b, .reg_req, .reg_rdata, .reg_rvalid,
        .mclk_pin, .general_pin_two, .bclk_pin, .pll_divided_output, .divider_path_output,
        .codec_core_clock_in, .divider_path_input, .pll_reference_input, .codec_rate_ratio,
        .legacy_left_attack_ms, .legacy_left_decay_ms, .legacy_right_attack_ms,
        .left_attack_ms, .left_decay_ms, .right_attack_ms
    );

    ccat_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    // read with valid pulse and data compared
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.read(a, d, v);
        chk("read valid", 16'h0001, {15'h0000, v});
        chk("read data", {8'h00, exp}, {8'h00, d});
    endtask : rd_chk

    // decay ceiling per codec rate ratio code (twice the ratio)
    function automatic logic [15:0] cap(input logic [3:0] r);
        case (r)
            4'h2: return 16'h0FA0;
            4'h3: return 16'h15E0;
            4'h4: return 16'h1F40;
            4'h5: return 16'h2580;
            4'h6, 4'h7: return 16'h2BC0;
            4'h8, 4'h9: return 16'h3E80;
            4'hA: return 16'h4B00;
            default: return 16'h5780;
        endcase
    endfunction : cap

    task automatic settle();
        @(posedge clock);
        #1;
    endtask : settle

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    // hang guard, well above the few thousand cycles the tests need
    initial
    begin
        #2000000;
        n_fail++;
        conclude();
    end

    initial
    begin
        logic [6:0] addrs [6];
        logic [7:0] rstv [6];
        logic [7:0] v;
        logic [15:0] e;
        addrs = '{7'h65, 7'h66, 7'h67, 7'h68, 7'h69, 7'h6A};
        rstv = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1'b1;
        // reset values, unmapped place reads zero
        for (int i = 0; i < 6; i++)
            rd_chk(addrs[i], rstv[i]);
        chk("left attack legacy", legacy_left_attack_ms, left_attack_ms);
        chk("right attack legacy", legacy_right_attack_ms, right_attack_ms);
        // unmapped write leaves nothing behind
        host.write(7'h6A, 8'hFF);
        rd_chk(7'h6A, 8'h00);
        // core clock source, both selections over all pin pairs
        for (int s = 0; s < 2; s++)
        begin
            host.write(7'h65, s[7:0]);
            rd_chk(7'h65, s[7:0]);
            for (int p = 0; p < 4; p++)
            begin
                settle();
                {pll_divided_output, divider_path_output} = p[1:0];
                #1;
                chk("core clock", {15'h0000, s[0] ? p[0] : p[1]}, {15'h0000, codec_core_clock_in});
            end
        end
        // divider and pll input sources, reserved code drives low
        for (int c = 0; c < 4; c++)
        begin
            host.write(7'h66, {c[1:0], 2'(3 - c), 4'h2});
            rd_chk(7'h66, {c[1:0], 2'(3 - c), 4'h2});
            for (int p = 0; p < 8; p++)
            begin
                settle();
                {mclk_pin, general_pin_two, bclk_pin} = p[2:0];
                #1;
                chk("divider input", {15'h0000, c == 3 ? 1'b0 : p[2 - c]}, {15'h0000, divider_path_input});
                chk("pll input", {15'h0000, c == 0 ? 1'b0 : p[c - 1]}, {15'h0000, pll_reference_input});
            end
        end
        // attack times on both channels, legacy path while select is clear
        for (int k = 0; k < 64; k++)
        begin
            v = {k[5:0], 2'h0};
            host.write(7'h67, v);
            host.write(7'h69, ~v & 8'hFC);
            // legacy sources move so a stale pass-through would show
            legacy_left_attack_ms = {k[7:0], 8'h34};
            legacy_right_attack_ms = {8'h0A, k[7:0]};
            settle();
            e = v[7] ? atk_tbl[v[6:5]] << v[4:2] : legacy_left_attack_ms;
            chk("left attack", e, left_attack_ms);
            e = ~v[7] ? atk_tbl[~v[6:5]] << ~v[4:2] : legacy_right_attack_ms;
            chk("right attack", e, right_attack_ms);
            rd_chk(7'h67, v);
        end
        // decay over every ratio code, ceiling only on the register path
        for (int r = 2; r < 14; r++)
        begin
            codec_rate_ratio = r[3:0];
            for (int k = 0; k < 64; k++)
            begin
                v = {k[5:0], 2'h0};
                host.write(7'h68, v);
                settle();
                e = dec_tbl[v[6:5]] << v[4:2];
                if (e > cap(r[3:0]))
                    e = cap(r[3:0]);
                if (!v[7])
                    e = legacy_left_decay_ms;
                chk("left decay", e, left_decay_ms);
            end
        end
        rd_chk(7'h68, 8'hFC);
        // reset in mid-run brings written registers back to their start values
        rst_b = 1'b0;
        repeat (2) settle();
        rst_b = 1'b1;
        rd_chk(7'h65, 8'h00);
        rd_chk(7'h66, 8'h02);
        rd_chk(7'h68, 8'h00);
        chk("left decay legacy", legacy_left_decay_ms, left_decay_ms);
        conclude();
    end
endmodule : ccat_regs_bench
`default_nettype wire
